// ===== pao_buf2.sv
// Purpose: two-entry skid buffer for output words
// Assumes: synchronous active-low reset
// Notes:   in_ready is registered, no word lost on stall
module pao_buf2
  import pao_pkg::*;
(
  // clock and reset
  input  wire logic      mclk,
  input  wire logic      reset_n,
  // fill side
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire pao_word_t in_word,
  // drain side
  output logic           out_valid,
  input  wire logic      out_ready,
  output pao_word_t      out_word
);
  pao_word_t  mem [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  wire        do_wr = in_valid && in_ready;
  wire        do_rd = out_valid && out_ready;
  wire [1:0]  next_count = count + {1'b0, do_wr} - {1'b0, do_rd};

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      count    <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      if (do_wr) wr_ptr <= ~wr_ptr;
      if (do_rd) rd_ptr <= ~rd_ptr;
      count    <= next_count;
      in_ready <= (next_count != 2'h2);
    end
  end

  always_ff @(posedge mclk) begin
    if (do_wr) mem[wr_ptr] <= in_word;
  end

  assign out_valid = (count != 2'h0);
  assign out_word  = mem[rd_ptr];

  a_buf_no_over : assert property (@(posedge mclk) disable iff (!reset_n)
    count <= 2'h2) else $error("buffer count overflow");
endmodule // pao_buf2

// ===== pao_cfg.svh
// Purpose: constants for the converter output port
// Assumes: one clock, mclk at 100 MHz
// Notes:   counts are in sample clock cycles
`ifndef PAO_CFG_SVH
`define PAO_CFG_SVH
`define PAO_WORD_W        10
`define PAO_MSB           9
`define PAO_LAT_CYCLES    7
`define PAO_WARMUP_CYCLES 20
`define PAO_CNT_W         5
`endif

// ===== pao_output_port.sv
// Purpose: digital face of a 10-bit pipelined sampling converter
// Assumes: mclk is the sample clock; samples arrive once per sample_tick
// Notes:   falling edge of sample clock modelled as a one-cycle sample_tick
//
// Functional notes
// - words count as valid only after twenty sample cycles of warm-up
// - format select low gives offset-binary words
// - format select high inverts msb giving two's-complement words
// - full scale codes follow from msb inversion of offset-binary
// - enable low drives data lines, high releases them
// - word for a sample appears seven sample cycles later
// - after latency one new word per sample cycle, no gaps
// - the sample command is the falling sample clock edge
// - two output register stages timed by the sample clock
`include "pao_cfg.svh"
module pao_output_port
  import pao_pkg::*;
(
  // clock and reset
  input  wire logic      mclk,
  input  wire logic      reset_n,
  // sample side
  input  wire logic      sample_tick,
  input  wire pao_word_t raw_sample,
  // format select (static) and output enable (may change each cycle)
  input  wire logic      code_format_select,
  input  wire logic      out_enable_n,
  // receiver side
  output pao_word_t      data_out,
  output pao_word_t      data_oe,
  output logic           data_valid,
  input  wire logic      rx_ready,
  output logic           tick_ready
);
  pao_state_t state;
  pao_state_t next_state;
  logic [`PAO_CNT_W-1:0] warm_cnt;
  pao_word_t  pipe [`PAO_LAT_CYCLES];
  logic [`PAO_LAT_CYCLES-1:0] pipe_vld;
  pao_word_t  stage_a;
  logic       stage_a_vld;
  logic       buf_in_ready;
  logic       buf_out_valid;
  pao_word_t  buf_out_word;
  logic [1:0] occ;

  // falling edge command, refused while no slot is promised
  wire take = sample_tick && tick_ready;
  // a taken tick pushes one post-warm-up word out of the pipe
  wire prod = take && pipe_vld[`PAO_LAT_CYCLES-1];
  wire drain = buf_out_valid && rx_ready;
  // stage_a keeps its word while the buffer is full, so none is lost
  wire hold_a = stage_a_vld && !buf_in_ready;
  // words in stage_a and buffer together; three slots in all
  wire [1:0] next_occ = occ + {1'b0, prod} - {1'b0, drain};
  wire pao_word_t coded = {pipe[`PAO_LAT_CYCLES-1][`PAO_MSB] ^ code_format_select,
                           pipe[`PAO_LAT_CYCLES-1][`PAO_MSB-1:0]};
  wire warm_done = (warm_cnt == `PAO_CNT_W'(`PAO_WARMUP_CYCLES - 1)) && take;
  // leave warm-up once, then stay running
  always_comb begin
    next_state = state;
    unique case (state)
      PAO_WARM: begin
        if (warm_done) next_state = PAO_RUN;
      end
      PAO_RUN: next_state = PAO_RUN;
      default: next_state = PAO_WARM;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state    <= PAO_WARM;
      warm_cnt <= '0;
    end else begin
      state <= next_state;
      if (state == PAO_WARM && take) warm_cnt <= warm_cnt + `PAO_CNT_W'(1);
    end
  end

  // seven-stage pipeline, advances once per sample
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pipe_vld <= '0;
    end else if (take) begin
      // warm-up samples enter untagged and never leave as words
      pipe_vld <= {pipe_vld[`PAO_LAT_CYCLES-2:0], state == PAO_RUN};
    end
  end

  // reset keeps unknowns out of the coding checks
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < `PAO_LAT_CYCLES; i++) pipe[i] <= '0;
    end else if (take) begin
      pipe[0] <= raw_sample;
      for (int i = 1; i < `PAO_LAT_CYCLES; i++) pipe[i] <= pipe[i-1];
    end
  end

  // occupancy of stage_a and buffer together
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      occ <= 2'h0;
    end else begin
      occ <= next_occ;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stage_a     <= '0;
      stage_a_vld <= 1'b0;
    end else if (!hold_a) begin
      stage_a     <= coded;
      stage_a_vld <= prod;
    end
  end

  // words are held when receiver stalls rather than dropped
  pao_buf2 u_buf (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (stage_a_vld),
    .in_ready  (buf_in_ready),
    .in_word   (stage_a),
    .out_valid (buf_out_valid),
    .out_ready (rx_ready),
    .out_word  (buf_out_word)
  );

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      data_out   <= '0;
      data_valid <= 1'b0;
      data_oe    <= '0;
      tick_ready <= 1'b0;
    end else begin
      if (drain) data_out <= buf_out_word;
      data_valid <= drain;
      data_oe    <= {`PAO_WORD_W{~out_enable_n}};
      // ready only while a slot stays free for the next word
      tick_ready <= (next_occ != 2'h3);
    end
  end

  a_no_early_word : assert property (@(posedge mclk) disable iff (!reset_n)
    (state == PAO_WARM) |-> !stage_a_vld)
    else $error("word left the pipe during warm-up");
  a_twos_msb : assert property (@(posedge mclk) disable iff (!reset_n)
    (code_format_select && !hold_a) |=> stage_a[`PAO_MSB] != $past(pipe[`PAO_LAT_CYCLES-1][`PAO_MSB]))
    else $error("msb not inverted in two's complement mode");
  a_offset_pass : assert property (@(posedge mclk) disable iff (!reset_n)
    (!code_format_select && !hold_a) |=> stage_a == $past(pipe[`PAO_LAT_CYCLES-1]))
    else $error("offset binary word altered");
  a_low_bits_same : assert property (@(posedge mclk) disable iff (!reset_n)
    !hold_a |=> stage_a[`PAO_MSB-1:0] == $past(pipe[`PAO_LAT_CYCLES-1][`PAO_MSB-1:0]))
    else $error("low bits changed by coding");
  a_oe_follow : assert property (@(posedge mclk) disable iff (!reset_n)
    out_enable_n |=> data_oe == '0)
    else $error("lines driven while output enable high");
  a_oe_drive : assert property (@(posedge mclk) disable iff (!reset_n)
    !out_enable_n |=> data_oe == '1)
    else $error("lines released while output enable low");
  a_latency_fill : assert property (@(posedge mclk) disable iff (!reset_n)
    stage_a_vld |-> $past(pipe_vld[`PAO_LAT_CYCLES-1]))
    else $error("word before pipeline latency");
  // second stage takes the drained word
  a_out_hand : assert property (@(posedge mclk) disable iff (!reset_n)
    (buf_out_valid && rx_ready) |=> data_valid && data_out == $past(buf_out_word))
    else $error("drained word not registered");
  // every late tick gives a word
  a_gapless : assert property (@(posedge mclk) disable iff (!reset_n)
    (state == PAO_RUN && pipe_vld[`PAO_LAT_CYCLES-1] && take) |=> stage_a_vld)
    else $error("tick after latency gave no word");
  a_warm_step : assert property (@(posedge mclk) disable iff (!reset_n)
    (state == PAO_WARM && take) |=> warm_cnt == $past(warm_cnt) + 1'b1 || state == PAO_RUN)
    else $error("warm-up count missed a tick");
  a_hold_keep : assert property (@(posedge mclk) disable iff (!reset_n)
    hold_a |=> stage_a_vld && $stable(stage_a))
    else $error("stalled word lost or changed");
  // taken tick always finds a slot
  a_tick_room : assert property (@(posedge mclk) disable iff (!reset_n)
    take |-> occ != 2'h3)
    else $error("tick taken with no free slot");
  // no drain from an empty path
  a_occ_drain : assert property (@(posedge mclk) disable iff (!reset_n)
    drain |-> occ != 2'h0)
    else $error("occupancy out of step with buffer");
  a_run_stays : assert property (@(posedge mclk) disable iff (!reset_n)
    (state == PAO_RUN) |=> (state == PAO_RUN))
    else $error("left running state without reset");
  a_warm_bound : assert property (@(posedge mclk) disable iff (!reset_n)
    (state == PAO_WARM) |-> warm_cnt < `PAO_CNT_W'(`PAO_WARMUP_CYCLES))
    else $error("warm-up count past its end");
  a_oe_uniform : assert property (@(posedge mclk) disable iff (!reset_n)
    data_oe == '0 || data_oe == '1)
    else $error("output enables split");
  a_valid_pulse : assert property (@(posedge mclk) disable iff (!reset_n)
    data_valid |-> $past(drain))
    else $error("data valid without a drained word");
  a_state_onehot : assert property (@(posedge mclk) disable iff (!reset_n)
    $onehot(state))
    else $error("illegal state code");

  c_run : cover property (@(posedge mclk) state == PAO_RUN);
  c_word : cover property (@(posedge mclk) data_valid);
  c_stall : cover property (@(posedge mclk) !buf_in_ready);
  c_twos : cover property (@(posedge mclk) data_valid && code_format_select);
  c_hold : cover property (@(posedge mclk) hold_a);
endmodule // pao_output_port

// ===== pao_pkg.sv
// Purpose: types for the converter output port
// Assumes: pao_cfg.svh constants
// Notes:   none
`include "pao_cfg.svh"
package pao_pkg;
  typedef logic [`PAO_WORD_W-1:0] pao_word_t;
  typedef enum logic [1:0] {
    PAO_WARM = 2'b01,
    PAO_RUN  = 2'b10
  } pao_state_t;
endpackage

// ===== pao_rx_model.sv
// Purpose: far-side logic that paces samples and stalls the word drain
// Assumes: mclk stands for the sample clock
// Notes:   stalls are random; no ticks until run
module pao_rx_model (
  // clock and control
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic tick_ready,
  // far-side strobes
  output logic      sample_tick = 1'b0,
  output logic      rx_ready    = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge mclk) begin
    sample_tick <= #1 run & tick_ready & ($urandom_range(3) != 0);
    rx_ready    <= #1 ~run | ($urandom_range(3) != 0);
  end
endmodule // pao_rx_model

// ===== tb_top.sv
// Purpose: self-checking bench for the converter output port
// Assumes: design assertions sit in the design files
// Notes:   format changes only across a reset
`include "pao_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pao_pkg::*;
  logic      mclk = 1'b0, reset_n = 1'b0, run = 1'b0, fmt = 1'b0, oe_n = 1'b0;
  logic      sample_tick, rx_ready, data_valid, tick_ready, oe_q, rst_q = 1'b0;
  pao_word_t raw = '0, data_out, data_oe, exp_w;
  pao_word_t exp_q[$];
  int        error_cnt = 0, tests_run = 0, acc = 0, words = 0;
  always #5 mclk = ~mclk;
  pao_output_port pao_output_port_i (.mclk(mclk), .reset_n(reset_n),
    .sample_tick(sample_tick), .raw_sample(raw), .code_format_select(fmt),
    .out_enable_n(oe_n), .data_out(data_out), .data_oe(data_oe),
    .data_valid(data_valid), .rx_ready(rx_ready), .tick_ready(tick_ready));
  pao_rx_model pao_rx_model_i (.mclk(mclk), .run(run), .tick_ready(tick_ready),
    .sample_tick(sample_tick), .rx_ready(rx_ready));
  task automatic check(input pao_word_t seen, input pao_word_t want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // warm-up samples never reach the output
  always @(posedge mclk) begin
    if (reset_n && sample_tick && tick_ready) begin
      if (acc >= `PAO_WARMUP_CYCLES)
        exp_q.push_back(fmt ? {~raw[`PAO_MSB], raw[`PAO_MSB-1:0]} : raw);
      acc++;
    end
  end
  always @(posedge mclk) begin
    if (rst_q) check(data_oe, {`PAO_WORD_W{~oe_q}});
    oe_q  = oe_n;
    rst_q = reset_n;
    if (reset_n && data_valid) begin
      words++;
      exp_w = exp_q.size() ? exp_q.pop_front() : ~data_out;
      check(data_out, exp_w);
    end
  end
  // hang guard, far above the expected run length
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(5));
    for (int f = 0; f < 2; f++) begin
      #1 reset_n = 1'b0;
      run = 1'b0;
      fmt = f[0];
      repeat (8) @(posedge mclk);
      acc = 0;
      words = 0;
      exp_q.delete();
      #1 reset_n = 1'b1;
      @(posedge mclk);
      #1 run = 1'b1;
      repeat (300) begin
        @(posedge mclk);
        // full-scale words mixed in with random ones
        #1 raw = ($urandom_range(3) == 0) ? {10{$urandom_range(1) == 1}} : pao_word_t'($urandom);
        oe_n = ($urandom_range(7) == 0);
      end
      run = 1'b0;
      repeat (10) @(posedge mclk);
      // last seven samples stay inside the pipeline
      check(pao_word_t'(words), pao_word_t'(acc - `PAO_WARMUP_CYCLES - `PAO_LAT_CYCLES));
    end
    test_done();
  end
endmodule // tb_top
